// ---- pkg/pvb_regs.svh ----
// Constants for the bridge pin-signalling block.
// Assumes a 50 MHz core clock; included by bare name.
`ifndef PVB_REGS_SVH
`define PVB_REGS_SVH

`define PVB_CLK_PERIOD_NS 20
// Least time the VME bus error stays asserted after a coupled target abort
`define PVB_BERR_HOLD_NS 80
`define PVB_BERR_HOLD_CYC ((`PVB_BERR_HOLD_NS + `PVB_CLK_PERIOD_NS - 1) / `PVB_CLK_PERIOD_NS)
`define PVB_BERR_CNT_W 4

// PCI command code and byte-enable values on C/BE#
`define PVB_CMD_MEM_WRITE 4'h7
`define PVB_BE_ALL_N 4'h0
`define PVB_BE_NONE_N 4'hf

// Target window: address bits from this index up must match the base
`define PVB_TGT_WIN_LSB 12
`define PVB_TGT_BASE_RST 32'h0010_0000

`endif

// ---- pkg/pvb_pkg.sv ----
// Types shared by the bridge pin-signalling block.
// No dependencies.
package pvb_pkg;
	typedef logic [7:1] pvb_irq_t;
	typedef enum logic [1:0] {V_IDLE, V_REQ, V_OWN} pvb_vme_state_t;
	typedef enum logic [1:0] {I_IDLE, I_ADDR, I_DATA, I_TURN} pvb_init_state_t;
	typedef enum logic [1:0] {T_IDLE, T_DATA, T_TURN} pvb_tgt_state_t;
endpackage

// ---- rtl/pvb_mem.sv ----
// Small word memory with registered read data.
// Assumes one clock; a write to the address being read is passed through.
module pvb_mem #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic core_clk_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic [AW-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);
	logic [WIDTH-1:0] store [DEPTH];

	always_ff @(posedge core_clk_i) begin
		if (wr_en_i) begin
			store[wr_addr_i] <= wr_data_i;
		end
		// Bypass so a word written into an empty FIFO is seen at once
		if (wr_en_i && wr_addr_i == rd_addr_i) begin
			rd_data_o <= wr_data_i;
		end else begin
			rd_data_o <= store[rd_addr_i];
		end
	end
endmodule

// ---- rtl/pvb_fifo.sv ----
// Valid/ready FIFO on top of the registered-read memory.
// Assumes one clock; ready and valid come from flip-flops.
module pvb_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 8
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (push) begin
			next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_o <= 1'b0;
			out_valid_o <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			in_ready_o <= next_count != FULL;
			out_valid_o <= next_count != '0;
		end
	end

	pvb_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
		.core_clk_i(core_clk_i),
		.wr_en_i(push),
		.wr_addr_i(wr_ptr),
		.wr_data_i(in_data_i),
		.rd_addr_i(next_rd_ptr),
		.rd_data_o(out_data_o)
	);
endmodule

// ---- rtl/pvb_pin_signalling.sv ----
// VME transmit-side outputs and a PCI initiator/target pin engine.
// Assumes all pin inputs already synchronous to core_clk_i; pad logic
// resolves each tri-state pin from its _oe output.
`include "pvb_regs.svh"

// Functional notes
// [RQ1] Bus busy driven while this side owns the VMEbus as master.
// [RQ2] Target abort on a coupled PCI access from VME raises VME bus error.
// [RQ3] One of four bus request lines asserted only while needing the bus; the code holds it until grant even if vme_need_i drops.
// [RQ4] Seven interrupt outputs, levels 1 to 7, each with its own blocking mask.
// [RQ5] System failure asserted during reset and held through automatic slot ID.
// [RQ6] Dedicated output drives the VMEbus system reset line.
// [RQ7] As target, assert 64-bit acknowledge when able to do 64-bit transfer.
// [RQ8] Lower AD lines multiplex address and data, a 32-bit path.
// [RQ9] Upper AD lines extend transfers to 64 bits when 64-bit is in use.
// [RQ10] C/BE lines carry command then byte enables; upper four only for 64-bit.
// [RQ11] DEVSEL driven to claim a transaction addressed to this target.
// [RQ12] Supply-current test enable input held low in normal operation.
// [RQ13] FRAME driven as initiator, sampled from others as target.
// [RQ14] Initiator starts only with grant asserted and bus idle.
module pvb_pin_signalling #(
	parameter int FIFO_DEPTH = 8,
	parameter logic [1:0] REQ_LEVEL = 2'd3,
	parameter logic [31:0] TGT_BASE = `PVB_TGT_BASE_RST
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	// VMEbus user side
	input wire logic vme_need_i,
	input wire logic vme_bus_grant_i,
	input wire pvb_pkg::pvb_irq_t irq_request_i,
	input wire pvb_pkg::pvb_irq_t irq_mask_i,
	input wire logic auto_id_done_i,
	input wire logic sysrst_request_i,
	input wire logic supply_current_test_enable_i,
	// VMEbus transmit pins
	output logic vme_tx_bus_busy_o,
	output logic vme_tx_bus_error_o,
	output logic [3:0] vme_tx_bus_request_o,
	output pvb_pkg::pvb_irq_t vme_tx_irq_o,
	output logic vme_tx_system_failure_o,
	output logic vme_tx_system_reset_o,
	// PCI initiator user side
	input wire logic init_start_i,
	input wire logic [31:0] init_addr_i,
	input wire logic [3:0] init_cmd_i,
	input wire logic [7:0] init_count_i,
	input wire logic init_wide_i,
	input wire logic init_coupled_i,
	input wire logic wr_valid_i,
	input wire logic [63:0] wr_data_i,
	output logic wr_ready_o,
	output logic init_busy_o,
	output logic init_abort_o,
	// PCI target user side
	output logic tgt_wr_valid_o,
	output logic [63:0] tgt_wr_data_o,
	// PCI pins
	input wire logic pci_gnt_n_i,
	input wire logic [63:0] pci_ad_i,
	input wire logic [7:0] pci_cbe_n_i,
	input wire logic pci_frame_n_i,
	input wire logic pci_irdy_n_i,
	input wire logic pci_trdy_n_i,
	input wire logic pci_devsel_n_i,
	input wire logic pci_stop_n_i,
	input wire logic pci_req64_n_i,
	input wire logic pci_ack64_n_i,
	output logic [63:0] pci_ad_o,
	output logic pci_ad_lo_oe_o,
	output logic pci_ad_hi_oe_o,
	output logic [7:0] pci_cbe_n_o,
	output logic pci_cbe_lo_oe_o,
	output logic pci_cbe_hi_oe_o,
	output logic pci_frame_n_o,
	output logic pci_frame_oe_o,
	output logic pci_irdy_n_o,
	output logic pci_irdy_oe_o,
	output logic pci_trdy_n_o,
	output logic pci_devsel_n_o,
	output logic pci_ack64_n_o,
	output logic pci_tgt_oe_o
);
	import pvb_pkg::*;

	function automatic logic tgt_hit(input logic [31:0] addr, input logic [3:0] cmd);
		tgt_hit = cmd == `PVB_CMD_MEM_WRITE &&
			addr[31:`PVB_TGT_WIN_LSB] == TGT_BASE[31:`PVB_TGT_WIN_LSB];
	endfunction

	pvb_vme_state_t vst, next_vst;
	pvb_init_state_t ist, next_ist;
	pvb_tgt_state_t tst, next_tst;

	// VME side state
	logic [3:0] next_bus_request;
	logic next_busy, next_berr, next_sysfail;
	logic [`PVB_BERR_CNT_W-1:0] berr_cnt, next_berr_cnt;
	pvb_irq_t next_irq;

	// Initiator state
	logic pend, next_pend, coupled, next_coupled, wide_req, next_wide_req;
	logic [31:0] addr, next_addr;
	logic [3:0] cmd, next_cmd;
	logic [7:0] left, next_left;
	logic [63:0] next_ad;
	logic [7:0] next_cbe;
	logic next_ad_lo_oe, next_ad_hi_oe, next_cbe_lo_oe, next_cbe_hi_oe;
	logic next_frame_n, next_frame_oe, next_irdy_n, next_irdy_oe, next_abort;
	logic fifo_valid, fifo_pop, coupled_abort, tgt_abort, word_done;
	logic [63:0] fifo_data;

	// Target state
	logic frame_prev, next_trdy_n, next_devsel_n, next_ack64_n, next_tgt_oe;
	logic next_tgt_valid;
	logic [63:0] next_tgt_data;

	pvb_fifo #(.WIDTH(64), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.in_valid_i(wr_valid_i),
		.in_data_i(wr_data_i),
		.in_ready_o(wr_ready_o),
		.out_valid_o(fifo_valid),
		.out_data_o(fifo_data),
		.out_ready_i(fifo_pop)
	);

	assign word_done = !pci_irdy_n_o && !pci_trdy_n_i;
	// Stop without device select is a target abort
	assign tgt_abort = ist == I_DATA && !pci_stop_n_i && pci_devsel_n_i;
	assign coupled_abort = tgt_abort && coupled;

	always_comb begin
		next_vst = vst;
		next_berr_cnt = berr_cnt;
		next_sysfail = vme_tx_system_failure_o && !auto_id_done_i;
		// [RQ4] per-level mask
		next_irq = irq_request_i & ~irq_mask_i;
		unique case (vst)
			V_IDLE: if (vme_need_i) next_vst = V_REQ;
			V_REQ: if (vme_bus_grant_i) next_vst = V_OWN;
			V_OWN: if (!vme_need_i) next_vst = V_IDLE;
		endcase
		// [RQ3] single request line
		next_bus_request = (next_vst == V_REQ) ? 4'h1 << REQ_LEVEL : 4'h0;
		// [RQ1] busy while master
		next_busy = next_vst == V_OWN;
		// [RQ2] abort hold
		if (coupled_abort) begin
			next_berr_cnt = `PVB_BERR_CNT_W'(`PVB_BERR_HOLD_CYC);
		end else if (berr_cnt != '0) begin
			next_berr_cnt = berr_cnt - 1'b1;
		end
		next_berr = next_berr_cnt != '0;
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			vst <= V_IDLE;
			berr_cnt <= '0;
			vme_tx_bus_busy_o <= 1'b0;
			vme_tx_bus_error_o <= 1'b0;
			vme_tx_bus_request_o <= 4'h0;
			vme_tx_irq_o <= '0;
			// [RQ5] failure shown from reset
			vme_tx_system_failure_o <= 1'b1;
			vme_tx_system_reset_o <= 1'b0;
		end else begin
			vst <= next_vst;
			berr_cnt <= next_berr_cnt;
			vme_tx_bus_busy_o <= next_busy;
			vme_tx_bus_error_o <= next_berr;
			vme_tx_bus_request_o <= next_bus_request;
			vme_tx_irq_o <= next_irq;
			vme_tx_system_failure_o <= next_sysfail;
			// [RQ6] system reset drive
			vme_tx_system_reset_o <= sysrst_request_i;
		end
	end

	always_comb begin
		next_ist = ist;
		next_pend = pend;
		next_addr = addr;
		next_cmd = cmd;
		next_left = left;
		next_coupled = coupled;
		next_wide_req = wide_req;
		next_ad = pci_ad_o;
		next_cbe = pci_cbe_n_o;
		next_ad_lo_oe = pci_ad_lo_oe_o;
		next_ad_hi_oe = pci_ad_hi_oe_o;
		next_cbe_lo_oe = pci_cbe_lo_oe_o;
		next_cbe_hi_oe = pci_cbe_hi_oe_o;
		next_frame_n = pci_frame_n_o;
		next_frame_oe = pci_frame_oe_o;
		next_irdy_n = pci_irdy_n_o;
		next_irdy_oe = pci_irdy_oe_o;
		next_abort = 1'b0;
		fifo_pop = 1'b0;
		if (init_start_i && !pend) begin
			next_pend = 1'b1;
			next_addr = init_addr_i;
			next_cmd = init_cmd_i;
			next_left = init_count_i;
			next_wide_req = init_wide_i;
			next_coupled = init_coupled_i;
		end
		unique case (ist)
			I_IDLE: begin
				// [RQ14] grant and idle bus; [RQ12] no new start under test
				if (pend && !pci_gnt_n_i && pci_frame_n_i && pci_irdy_n_i &&
					tst == T_IDLE && !supply_current_test_enable_i) begin
					next_ist = I_ADDR;
					// [RQ13] frame as initiator
					next_frame_n = 1'b0;
					next_frame_oe = 1'b1;
					// [RQ8] address phase on low lines
					next_ad = {32'h0, addr};
					next_ad_lo_oe = 1'b1;
					next_cbe = {`PVB_BE_NONE_N, cmd};
					next_cbe_lo_oe = 1'b1;
				end
			end
			I_ADDR: begin
				next_ist = I_DATA;
				next_irdy_oe = 1'b1;
				next_cbe[3:0] = `PVB_BE_ALL_N;
			end
			I_DATA: begin
				if (tgt_abort || (word_done && pci_frame_n_o)) begin
					next_ist = I_TURN;
					next_abort = tgt_abort;
					next_frame_n = 1'b1;
					next_irdy_n = 1'b1;
					next_ad_hi_oe = 1'b0;
					next_cbe_hi_oe = 1'b0;
					next_pend = 1'b0;
				end else if (pci_irdy_n_o || word_done) begin
					// Width fixed per word from the target's acknowledge
					if (fifo_valid && !pci_devsel_n_i) begin
						fifo_pop = 1'b1;
						next_irdy_n = 1'b0;
						next_left = left - 1'b1;
						next_frame_n = left == 8'h1;
						// [RQ9] [RQ10] upper lanes only for 64-bit
						next_ad_hi_oe = wide_req && !pci_ack64_n_i;
						next_cbe_hi_oe = next_ad_hi_oe;
						next_cbe[7:4] = `PVB_BE_ALL_N;
						next_ad = next_ad_hi_oe ? fifo_data : {32'h0, fifo_data[31:0]};
					end else begin
						next_irdy_n = 1'b1;
					end
				end
			end
			I_TURN: begin
				next_ist = I_IDLE;
				next_frame_oe = 1'b0;
				next_irdy_oe = 1'b0;
				next_ad_lo_oe = 1'b0;
				next_cbe_lo_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ist <= I_IDLE;
			pend <= 1'b0;
			addr <= 32'h0;
			cmd <= 4'h0;
			left <= 8'h0;
			coupled <= 1'b0;
			wide_req <= 1'b0;
			pci_ad_o <= 64'h0;
			pci_cbe_n_o <= 8'hff;
			pci_ad_lo_oe_o <= 1'b0;
			pci_ad_hi_oe_o <= 1'b0;
			pci_cbe_lo_oe_o <= 1'b0;
			pci_cbe_hi_oe_o <= 1'b0;
			pci_frame_n_o <= 1'b1;
			pci_frame_oe_o <= 1'b0;
			pci_irdy_n_o <= 1'b1;
			pci_irdy_oe_o <= 1'b0;
			init_busy_o <= 1'b0;
			init_abort_o <= 1'b0;
		end else begin
			ist <= next_ist;
			pend <= next_pend;
			addr <= next_addr;
			cmd <= next_cmd;
			left <= next_left;
			coupled <= next_coupled;
			wide_req <= next_wide_req;
			pci_ad_o <= next_ad;
			pci_cbe_n_o <= next_cbe;
			pci_ad_lo_oe_o <= next_ad_lo_oe;
			pci_ad_hi_oe_o <= next_ad_hi_oe;
			pci_cbe_lo_oe_o <= next_cbe_lo_oe;
			pci_cbe_hi_oe_o <= next_cbe_hi_oe;
			pci_frame_n_o <= next_frame_n;
			pci_frame_oe_o <= next_frame_oe;
			pci_irdy_n_o <= next_irdy_n;
			pci_irdy_oe_o <= next_irdy_oe;
			init_busy_o <= next_pend;
			init_abort_o <= next_abort;
		end
	end

	always_comb begin
		next_tst = tst;
		next_devsel_n = pci_devsel_n_o;
		next_trdy_n = pci_trdy_n_o;
		next_ack64_n = pci_ack64_n_o;
		next_tgt_oe = pci_tgt_oe_o;
		next_tgt_valid = 1'b0;
		next_tgt_data = tgt_wr_data_o;
		unique case (tst)
			T_IDLE: begin
				// [RQ13] sample others' frame start; [RQ11] claim on hit
				if (!pci_frame_n_i && frame_prev && ist == I_IDLE &&
					tgt_hit(pci_ad_i[31:0], pci_cbe_n_i[3:0])) begin
					next_tst = T_DATA;
					next_devsel_n = 1'b0;
					next_trdy_n = 1'b0;
					// [RQ7] acknowledge 64-bit when requested
					next_ack64_n = pci_req64_n_i;
					next_tgt_oe = 1'b1;
				end
			end
			T_DATA: begin
				if (!pci_irdy_n_i) begin
					next_tgt_valid = 1'b1;
					next_tgt_data = pci_ack64_n_o ? {32'h0, pci_ad_i[31:0]} : pci_ad_i;
					if (pci_frame_n_i) begin
						next_tst = T_TURN;
						next_devsel_n = 1'b1;
						next_trdy_n = 1'b1;
						next_ack64_n = 1'b1;
					end
				end
			end
			T_TURN: begin
				next_tst = T_IDLE;
				next_tgt_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			tst <= T_IDLE;
			frame_prev <= 1'b1;
			pci_devsel_n_o <= 1'b1;
			pci_trdy_n_o <= 1'b1;
			pci_ack64_n_o <= 1'b1;
			pci_tgt_oe_o <= 1'b0;
			tgt_wr_valid_o <= 1'b0;
			tgt_wr_data_o <= 64'h0;
		end else begin
			tst <= next_tst;
			frame_prev <= pci_frame_n_i;
			pci_devsel_n_o <= next_devsel_n;
			pci_trdy_n_o <= next_trdy_n;
			pci_ack64_n_o <= next_ack64_n;
			pci_tgt_oe_o <= next_tgt_oe;
			tgt_wr_valid_o <= next_tgt_valid;
			tgt_wr_data_o <= next_tgt_data;
		end
	end

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	a_busy_after_grant: assert property ($rose(vme_tx_bus_busy_o) |-> // [RQ1]
		$past(vme_bus_grant_i) && $past(vme_tx_bus_request_o) != 4'h0)
		else $error("bus busy without grant");
	a_request_one_line: assert property ($onehot0(vme_tx_bus_request_o) && // [RQ3]
		!(vme_tx_bus_busy_o && vme_tx_bus_request_o != 4'h0))
		else $error("bad bus request lines");
	a_berr_on_abort: assert property (coupled_abort |=> // [RQ2]
		vme_tx_bus_error_o [*4] ##1 !vme_tx_bus_error_o)
		else $error("bus error not held after abort");
	a_irq_masked: assert property (##1 vme_tx_irq_o == // [RQ4]
		($past(irq_request_i) & ~$past(irq_mask_i)))
		else $error("interrupt mask not applied");
	a_sysfail_until_id: assert property ($fell(vme_tx_system_failure_o) |-> // [RQ5]
		$past(auto_id_done_i))
		else $error("system failure dropped early");
	a_sysrst_follows: assert property ($changed(vme_tx_system_reset_o) |-> // [RQ6]
		vme_tx_system_reset_o == $past(sysrst_request_i) || $past(reset_i))
		else $error("system reset not following request");
	a_frame_needs_gnt: assert property ($fell(pci_frame_n_o) |-> // [RQ14]
		$past(!pci_gnt_n_i && pci_frame_n_i && pci_irdy_n_i))
		else $error("frame started without grant or idle bus");
	a_devsel_on_hit: assert property ($fell(pci_devsel_n_o) |-> // [RQ11]
		$past(tgt_hit(pci_ad_i[31:0], pci_cbe_n_i[3:0])) && pci_tgt_oe_o)
		else $error("device select without address hit");
	a_ack64_with_devsel: assert property (!pci_ack64_n_o |-> // [RQ7]
		!pci_devsel_n_o && $past(!pci_req64_n_i, 1) || $past(!pci_ack64_n_o))
		else $error("64-bit acknowledge without claim");
	a_upper_lanes_wide: assert property (pci_ad_hi_oe_o |-> // [RQ10]
		wide_req && pci_cbe_hi_oe_o && ist == I_DATA)
		else $error("upper lanes driven outside 64-bit data");

	c_vme_owned: cover property (vme_tx_bus_request_o != 4'h0 ##[1:20] vme_tx_bus_busy_o);
	c_init_done: cover property (ist == I_DATA && word_done && pci_frame_n_o);
	c_tgt_write: cover property (tgt_wr_valid_o && !pci_ack64_n_o);
	c_abort_berr: cover property (coupled_abort ##1 vme_tx_bus_error_o);
endmodule

// ---- bench/pvb_target_model.sv ----
// Behavioural PCI target that answers the block's initiator writes.
// Assumes resolved pin levels on its inputs; its control outputs idle high.
module pvb_target_model (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic enable_i,
	input wire logic wide_i,
	input wire logic slow_i,
	input wire logic abort_i,
	input wire logic frame_n_i,
	input wire logic irdy_n_i,
	input wire logic [63:0] ad_i,
	input wire logic [7:0] cbe_n_i,
	output logic devsel_n_o,
	output logic trdy_n_o,
	output logic stop_n_o,
	output logic ack64_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic frame_q, active;
	logic [31:0] addr;
	logic [3:0] cmd;
	logic [63:0] words [0:15];
	int n_got;

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			{devsel_n_o, trdy_n_o, stop_n_o, ack64_n_o, frame_q} <= 5'h1f;
			active <= 1'b0;
			n_got <= 0;
		end else begin
			frame_q <= frame_n_i;
			if (!active) begin
				if (enable_i && frame_q && !frame_n_i) begin
					active <= 1'b1;
					addr <= ad_i[31:0];
					cmd <= cbe_n_i[3:0];
					devsel_n_o <= 1'b0;
					ack64_n_o <= ~wide_i;
				end
			end else if (abort_i) begin
				// Stop without devsel until the frame ends
				devsel_n_o <= 1'b1;
				ack64_n_o <= 1'b1;
				stop_n_o <= frame_n_i;
				active <= ~frame_n_i;
			end else if (!trdy_n_o && !irdy_n_i) begin
				words[n_got % 16] <= ack64_n_o ? {32'h0, ad_i[31:0]} : ad_i;
				n_got <= n_got + 1;
				trdy_n_o <= slow_i | frame_n_i;
				if (frame_n_i) begin
					{devsel_n_o, ack64_n_o} <= 2'h3;
					active <= 1'b0;
				end
			end else if (trdy_n_o) begin
				trdy_n_o <= 1'b0;
			end
		end
	end
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the bridge pin-signalling block.
// Assumes the target model is compiled first; the bench resolves the pins.
`include "pvb_regs.svh"
module testbench import pvb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FIFO_DEPTH = 8;
	localparam logic [1:0] REQ_LEVEL = 2'd3;
	logic core_clk_i = 1'b0, reset_i = 1'b1, vme_need_i = 1'b0, vme_bus_grant_i = 1'b0;
	pvb_irq_t irq_request_i = '0, irq_mask_i = '0;
	logic auto_id_done_i = 1'b0, sysrst_request_i = 1'b0;
	logic supply_current_test_enable_i = 1'b0;
	logic init_start_i = 1'b0, init_wide_i = 1'b0, init_coupled_i = 1'b0, wr_valid_i = 1'b0;
	logic [31:0] init_addr_i = '0;
	logic [3:0] init_cmd_i = '0;
	logic [7:0] init_count_i = 8'h01;
	logic [63:0] wr_data_i = '0, t_ad = '0, ad_last = '0, pci_ad_i, pci_ad_o, tgt_wr_data_o;
	logic [7:0] t_cbe_n = 8'hff, cbe_last = '0, pci_cbe_n_i, pci_cbe_n_o;
	logic pci_gnt_n_i = 1'b1, pci_req64_n_i = 1'b1, t_oe = 1'b0, t_frame_n = 1'b1;
	logic t_irdy_n = 1'b1, m_en = 1'b0, m_wide = 1'b0, m_slow = 1'b0, m_abort = 1'b0;
	logic m_devsel_n, m_trdy_n, pci_stop_n_i, m_ack64_n;
	logic pci_frame_n_i, pci_irdy_n_i, pci_trdy_n_i, pci_devsel_n_i, pci_ack64_n_i;
	logic vme_tx_bus_busy_o, vme_tx_bus_error_o, vme_tx_system_failure_o, vme_tx_system_reset_o;
	logic [3:0] vme_tx_bus_request_o;
	pvb_irq_t vme_tx_irq_o;
	logic wr_ready_o, init_busy_o, init_abort_o, tgt_wr_valid_o, pci_ad_lo_oe_o, pci_ad_hi_oe_o;
	logic pci_cbe_lo_oe_o, pci_cbe_hi_oe_o, pci_frame_n_o, pci_frame_oe_o, pci_irdy_n_o;
	logic pci_irdy_oe_o, pci_trdy_n_o, pci_devsel_n_o, pci_ack64_n_o, pci_tgt_oe_o;
	int n_errors = 0, tests_run = 0;

	// Undriven lines show the inverse of their last level, never a stale match
	assign pci_ad_i[31:0] = pci_ad_lo_oe_o ? pci_ad_o[31:0] : t_oe ? t_ad[31:0] : ~ad_last[31:0];
	assign pci_ad_i[63:32] = pci_ad_hi_oe_o ? pci_ad_o[63:32] : t_oe ? t_ad[63:32] : ~ad_last[63:32];
	assign pci_cbe_n_i[3:0] = pci_cbe_lo_oe_o ? pci_cbe_n_o[3:0] : t_oe ? t_cbe_n[3:0] : ~cbe_last[3:0];
	assign pci_cbe_n_i[7:4] = pci_cbe_hi_oe_o ? pci_cbe_n_o[7:4] : t_oe ? t_cbe_n[7:4] : ~cbe_last[7:4];
	// Control lines carry pull-ups
	assign pci_frame_n_i = pci_frame_oe_o ? pci_frame_n_o : t_oe ? t_frame_n : 1'b1;
	assign pci_irdy_n_i = pci_irdy_oe_o ? pci_irdy_n_o : t_oe ? t_irdy_n : 1'b1;
	assign pci_trdy_n_i = (pci_tgt_oe_o ? pci_trdy_n_o : 1'b1) & m_trdy_n;
	assign pci_devsel_n_i = (pci_tgt_oe_o ? pci_devsel_n_o : 1'b1) & m_devsel_n;
	assign pci_ack64_n_i = (pci_tgt_oe_o ? pci_ack64_n_o : 1'b1) & m_ack64_n;
	always @(posedge core_clk_i) begin
		ad_last <= pci_ad_i;
		cbe_last <= pci_cbe_n_i;
	end

	pvb_pin_signalling #(.FIFO_DEPTH(FIFO_DEPTH), .REQ_LEVEL(REQ_LEVEL)) pvb_pin_signalling_i (
		.core_clk_i, .reset_i, .vme_need_i, .vme_bus_grant_i, .irq_request_i, .irq_mask_i,
		.auto_id_done_i, .sysrst_request_i, .supply_current_test_enable_i, .vme_tx_bus_busy_o,
		.vme_tx_bus_error_o, .vme_tx_bus_request_o, .vme_tx_irq_o, .vme_tx_system_failure_o,
		.vme_tx_system_reset_o, .init_start_i, .init_addr_i, .init_cmd_i, .init_count_i,
		.init_wide_i, .init_coupled_i, .wr_valid_i, .wr_data_i, .wr_ready_o, .init_busy_o,
		.init_abort_o, .tgt_wr_valid_o, .tgt_wr_data_o, .pci_gnt_n_i, .pci_ad_i, .pci_cbe_n_i,
		.pci_frame_n_i, .pci_irdy_n_i, .pci_trdy_n_i, .pci_devsel_n_i, .pci_stop_n_i,
		.pci_req64_n_i, .pci_ack64_n_i, .pci_ad_o, .pci_ad_lo_oe_o, .pci_ad_hi_oe_o, .pci_cbe_n_o,
		.pci_cbe_lo_oe_o, .pci_cbe_hi_oe_o, .pci_frame_n_o, .pci_frame_oe_o, .pci_irdy_n_o,
		.pci_irdy_oe_o, .pci_trdy_n_o, .pci_devsel_n_o, .pci_ack64_n_o, .pci_tgt_oe_o
	);
	pvb_target_model pvb_target_model_i (
		.core_clk_i, .reset_i, .enable_i(m_en), .wide_i(m_wide), .slow_i(m_slow),
		.abort_i(m_abort), .frame_n_i(pci_frame_n_i), .irdy_n_i(pci_irdy_n_i), .ad_i(pci_ad_i),
		.cbe_n_i(pci_cbe_n_i), .devsel_n_o(m_devsel_n), .trdy_n_o(m_trdy_n),
		.stop_n_o(pci_stop_n_i), .ack64_n_o(m_ack64_n)
	);

	task automatic give_verdict();
		$display("Mismatches %0d of %0d comparisons", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bound(input int i, input int lim);
		if (i >= lim) begin
			n_errors++;
			$display("CHECK FAILED at %0t wait ran out", $time);
			give_verdict();
		end
	endtask
	task automatic settle();
		@(posedge core_clk_i);
		@(negedge core_clk_i);
	endtask
	function automatic logic [63:0] pat(input int k);
		return {32'hc0de_0000 + k[31:0], 32'h5a00_0000 + k[31:0]};
	endfunction
	task automatic push(input logic [63:0] d);
		int i;
		@(posedge core_clk_i);
		wr_valid_i <= 1'b1;
		wr_data_i <= d;
		for (i = 0; i < 50; i++) begin
			@(posedge core_clk_i);
			if (wr_ready_o === 1'b1) break;
		end
		bound(i, 50);
		wr_valid_i <= 1'b0;
	endtask
	task automatic watch(inout int nb, inout int na);
		@(negedge core_clk_i);
		if (vme_tx_bus_error_o === 1'b1) nb++;
		if (init_abort_o === 1'b1) na++;
	endtask

	task automatic reset_check();
		repeat (10) @(posedge core_clk_i);
		@(negedge core_clk_i);
		check(vme_tx_system_failure_o, 1'b1);
		check({vme_tx_bus_busy_o, vme_tx_bus_request_o, vme_tx_system_reset_o}, 6'h00);
		check({pci_ad_lo_oe_o, pci_frame_oe_o, pci_tgt_oe_o}, 3'h0);
		repeat (10) @(posedge core_clk_i);
		reset_i <= 1'b0;
		settle();
		check(vme_tx_system_failure_o, 1'b1);
		@(posedge core_clk_i);
		auto_id_done_i <= 1'b1;
		@(posedge core_clk_i);
		auto_id_done_i <= 1'b0;
		@(negedge core_clk_i);
		check(vme_tx_system_failure_o, 1'b0);
	endtask
	task automatic vme_arb();
		@(posedge core_clk_i);
		vme_need_i <= 1'b1;
		settle();
		check(vme_tx_bus_request_o, 4'h1 << REQ_LEVEL);
		check(vme_tx_bus_busy_o, 1'b0);
		@(posedge core_clk_i);
		vme_bus_grant_i <= 1'b1;
		settle();
		check({vme_tx_bus_busy_o, vme_tx_bus_request_o}, 5'h10);
		@(posedge core_clk_i);
		vme_need_i <= 1'b0;
		vme_bus_grant_i <= 1'b0;
		settle();
		check({vme_tx_bus_busy_o, vme_tx_bus_request_o}, 5'h00);
	endtask
	task automatic irq_levels();
		int k;
		pvb_irq_t r;
		for (k = 1; k <= 8; k++) begin
			r = '0;
			if (k < 8) r[k] = 1'b1;
			@(posedge core_clk_i);
			irq_request_i <= (k < 8) ? 7'h7f : 7'h00;
			irq_mask_i <= ~r;
			settle();
			check(vme_tx_irq_o, r);
		end
	endtask
	task automatic sys_reset();
		@(posedge core_clk_i);
		sysrst_request_i <= 1'b1;
		settle();
		check(vme_tx_system_reset_o, 1'b1);
		@(posedge core_clk_i);
		sysrst_request_i <= 1'b0;
		settle();
		check(vme_tx_system_reset_o, 1'b0);
	endtask
	task automatic init_run(input int n, input logic want, ack, coupled, slow, abort);
		int i, base, nb, na;
		logic [31:0] a;
		logic [63:0] e;
		base = pvb_target_model_i.n_got;
		nb = 0;
		na = 0;
		a = 32'h4000_0000 + 32'(n * 16);
		for (i = 0; i < n; i++) push(pat(i));
		settle();
		// A full buffer refuses further words
		if (n == FIFO_DEPTH) check(wr_ready_o, 1'b0);
		@(posedge core_clk_i);
		{m_en, m_wide, m_slow, m_abort} <= {1'b1, ack, slow, abort};
		{init_start_i, init_wide_i, init_coupled_i} <= {1'b1, want, coupled};
		init_addr_i <= a;
		init_cmd_i <= `PVB_CMD_MEM_WRITE;
		init_count_i <= 8'(n);
		@(posedge core_clk_i);
		init_start_i <= 1'b0;
		repeat (3) begin
			@(negedge core_clk_i);
			check(init_busy_o, 1'b1);
			check(pci_frame_oe_o, 1'b0);
		end
		// Strap high holds off a start even with grant
		@(posedge core_clk_i);
		pci_gnt_n_i <= 1'b0;
		supply_current_test_enable_i <= 1'b1;
		settle();
		check(pci_frame_oe_o, 1'b0);
		@(posedge core_clk_i);
		supply_current_test_enable_i <= 1'b0;
		for (i = 0; i < 400; i++) begin
			watch(nb, na);
			if (init_busy_o === 1'b0) break;
		end
		bound(i, 400);
		repeat (8) watch(nb, na);
		@(posedge core_clk_i);
		pci_gnt_n_i <= 1'b1;
		check(na, abort);
		check(nb, (abort && coupled) ? 4 : 0);
		if (!abort) begin
			check(pvb_target_model_i.addr, a);
			check(pvb_target_model_i.cmd, `PVB_CMD_MEM_WRITE);
			for (i = 0; i < n; i++) begin
				e = pat(i);
				check(pvb_target_model_i.words[(base + i) % 16], (want && ack) ? e : e & 64'hffff_ffff);
			end
		end
	endtask
	task automatic tgt_write(input logic [31:0] a, input logic hit);
		@(posedge core_clk_i);
		{m_en, t_oe, t_frame_n, pci_req64_n_i} <= 4'h4;
		t_ad <= {32'h0, a};
		t_cbe_n <= {4'hf, `PVB_CMD_MEM_WRITE};
		@(posedge core_clk_i);
		t_irdy_n <= 1'b0;
		t_ad <= pat(20);
		t_cbe_n <= 8'h00;
		@(negedge core_clk_i);
		check(pci_tgt_oe_o, hit);
		if (hit) check({pci_devsel_n_o, pci_ack64_n_o}, 2'h0);
		@(posedge core_clk_i);
		t_frame_n <= 1'b1;
		t_ad <= pat(21);
		@(negedge core_clk_i);
		check(tgt_wr_valid_o, hit);
		if (hit) check(tgt_wr_data_o, pat(20));
		@(posedge core_clk_i);
		t_irdy_n <= 1'b1;
		@(negedge core_clk_i);
		check(tgt_wr_valid_o, hit);
		if (hit) check(tgt_wr_data_o, pat(21));
		@(posedge core_clk_i);
		t_oe <= 1'b0;
		pci_req64_n_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
	endtask

	initial begin
		forever #10 core_clk_i = ~core_clk_i;
	end
	initial begin
		reset_check();
		vme_arb();
		irq_levels();
		sys_reset();
		init_run(FIFO_DEPTH, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
		init_run(2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		tgt_write(`PVB_TGT_BASE_RST + 32'h40, 1'b1);
		tgt_write(`PVB_TGT_BASE_RST + 32'h1000, 1'b0);
		init_run(1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
		init_run(1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		give_verdict();
	end
endmodule
